// >>> inc/oms_pkg.sv
// Shared constants for the optical module management two-wire link
// Operation
// (R1) Transmit half answers at address 50h
// (R2) Receive half answers at address 54h
// (R3) Host drives select low to address module
// (R4) Selected module takes part in transactions
// (R5) Deselected module never acknowledges nor acts
// (R6) Host clocks bus between 5 and 400 kHz
// (R7) Select low 2 ms before START
// (R8) Wait 10 us after sequence before select change
// (R9) Deselect aborts, releases lines within 2 ms
// (R10) Host avoids two modules answering at once
// (R11) Module is slave only, host initiates
// (R12) Clock stretch released within 500 us
// (R13) Writes carry 1 to 4 bytes
// (R14) Write completes within 40 ms after STOP
// (R15) Foreign addresses left unacknowledged
package oms_pkg;
	localparam logic [6:0] OMS_TX_ADDR = 7'h50;
	localparam logic [6:0] OMS_RX_ADDR = 7'h54;
	localparam logic OMS_RD_BIT = 1'b1;
	localparam logic [2:0] OMS_MAX_WR = 3'h4;
	localparam int OMS_CLK_KHZ = 100000;
	localparam int OMS_SCL_MAX_KHZ = 400;
	localparam int OMS_SCL_MIN_KHZ = 5;
	// Quarter bit period, rounded up so the bus never beats the top rate
	localparam int OMS_QTR_CYC = (OMS_CLK_KHZ + 4 * OMS_SCL_MAX_KHZ - 1) / (4 * OMS_SCL_MAX_KHZ);
	localparam int OMS_SEL_SETUP_MS = 2;
	localparam int OMS_SEL_SETUP_CYC = OMS_SEL_SETUP_MS * OMS_CLK_KHZ;
	localparam int OMS_SEL_HOLD_US = 10;
	localparam int OMS_SEL_HOLD_CYC = (OMS_SEL_HOLD_US * OMS_CLK_KHZ + 999) / 1000;
	localparam int OMS_STRETCH_US = 500;
	localparam int OMS_STRETCH_CYC = OMS_STRETCH_US * OMS_CLK_KHZ / 1000;
	localparam int OMS_WRITE_MS = 40;
	localparam int OMS_WRITE_CYC = OMS_WRITE_MS * OMS_CLK_KHZ;
	localparam logic [7:0] OMS_IDLE_BYTE = 8'hff;
endpackage

// >>> inc/oms_link_if.sv
// Two-wire link with module select between host and module
`timescale 1ns/100ps
interface oms_link_if;
	logic host_scl_o;
	logic host_scl_oe;
	logic host_sda_o;
	logic host_sda_oe;
	logic dev_scl_o;
	logic dev_scl_oe;
	logic dev_sda_o;
	logic dev_sda_oe;
	logic module_select_n;
	logic scl;
	logic sda;
	// Open drain with pull-up: any enabled low driver wins
	assign scl = ~((host_scl_oe & ~host_scl_o) | (dev_scl_oe & ~dev_scl_o));
	assign sda = ~((host_sda_oe & ~host_sda_o) | (dev_sda_oe & ~dev_sda_o));
	modport host (output host_scl_o, host_scl_oe, host_sda_o, host_sda_oe, module_select_n,
		input scl, sda);
	modport dev (output dev_scl_o, dev_scl_oe, dev_sda_o, dev_sda_oe,
		input scl, sda, module_select_n);
endinterface

// >>> rtl/oms_dev_end.sv
// Module end: two-wire slave for the transmit and receive halves
`timescale 1ns/100ps
module oms_dev_end #(
	parameter int STRETCH_CYC = oms_pkg::OMS_STRETCH_CYC,
	parameter int WRITE_CYC = oms_pkg::OMS_WRITE_CYC
) (
	input wire logic clk_in,
	input wire logic arst_n_in,
	oms_link_if.dev link,
	output logic wr_valid_out,
	output logic wr_half_out,
	output logic [1:0] wr_index_out,
	output logic [7:0] wr_data_out,
	output logic wr_commit_out,
	output logic rd_req_out,
	output logic rd_half_out,
	output logic [1:0] rd_index_out,
	input wire logic [7:0] rd_data_in,
	input wire logic rd_valid_in,
	output logic busy_out
);
	import oms_pkg::*;

	typedef enum logic [3:0] {
		DS_IDLE = 4'h0,
		DS_ADDR = 4'h1,
		DS_AACK = 4'h3,
		DS_WR = 4'h2,
		DS_WACK = 4'h6,
		DS_FETCH = 4'h7,
		DS_RD = 4'h5,
		DS_RACK = 4'h4,
		DS_SKIP = 4'hc
	} oms_dstate_type;

	////////////////////////////////////////////////////////////////////////////////
	// Link domain: bits shift in on the rising serial clock
	logic [7:0] lbyte_r;
	logic [7:0] lbyte_nxt;

	always_comb begin
		lbyte_nxt = {lbyte_r[6:0], link.sda};
	end

	always_ff @(posedge link.scl or negedge arst_n_in) begin
		if (!arst_n_in) begin
			lbyte_r <= '0;
		end else begin
			lbyte_r <= lbyte_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Crossing: the byte is stable from its 8th rise until the 9th, far
	// longer than the two-flop delay, and is only read after the 8th fall
	logic [10:0] s1_r;
	logic [10:0] s2_r;
	logic [1:0] p_r;
	logic scl_s;
	logic sda_s;
	logic sel_n_s;
	logic [7:0] byte_s;

	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			s1_r <= 11'h7ff;
			s2_r <= 11'h7ff;
			p_r <= 2'h3;
		end else begin
			s1_r <= {lbyte_r, link.module_select_n, link.sda, link.scl};
			s2_r <= s1_r;
			p_r <= s2_r[1:0];
		end
	end

	assign scl_s = s2_r[0];
	assign sda_s = s2_r[1];
	assign sel_n_s = s2_r[2];
	assign byte_s = s2_r[10:3];

	logic rise;
	logic fall;
	logic start_ev;
	logic stop_ev;
	assign rise = scl_s & ~p_r[0];
	assign fall = ~scl_s & p_r[0];
	assign start_ev = scl_s & p_r[0] & p_r[1] & ~sda_s;
	assign stop_ev = scl_s & p_r[0] & ~p_r[1] & sda_s;

	////////////////////////////////////////////////////////////////////////////////
	// Protocol engine
	oms_dstate_type state_r, state_nxt;
	logic [3:0] bit_r, bit_nxt;
	logic [2:0] nbytes_r, nbytes_nxt;
	logic [7:0] sh_r, sh_nxt;
	logic half_r, half_nxt;
	logic rnw_r, rnw_nxt;
	logic mack_r, mack_nxt;
	logic sda_oe_r, sda_oe_nxt;
	logic scl_oe_r, scl_oe_nxt;
	logic [31:0] cnt_r, cnt_nxt;
	logic [31:0] busy_r, busy_nxt;
	logic wr_valid_r, wr_valid_nxt;
	logic [1:0] wr_index_r, wr_index_nxt;
	logic [7:0] wr_data_r, wr_data_nxt;
	logic commit_r, commit_nxt;
	logic rd_req_r, rd_req_nxt;
	logic [6:0] addr;
	logic hit;

	assign addr = byte_s[7:1];
	assign hit = (addr == OMS_TX_ADDR) || (addr == OMS_RX_ADDR); // see (R1) see (R2)

	always_comb begin
		state_nxt = state_r;
		bit_nxt = bit_r;
		nbytes_nxt = nbytes_r;
		sh_nxt = sh_r;
		half_nxt = half_r;
		rnw_nxt = rnw_r;
		mack_nxt = mack_r;
		sda_oe_nxt = sda_oe_r;
		scl_oe_nxt = scl_oe_r;
		cnt_nxt = cnt_r;
		busy_nxt = (busy_r != 32'h0) ? busy_r - 32'h1 : 32'h0;
		wr_valid_nxt = 1'b0;
		wr_index_nxt = wr_index_r;
		wr_data_nxt = wr_data_r;
		commit_nxt = 1'b0;
		rd_req_nxt = 1'b0;
		if (sel_n_s) begin
			// Deselect returns to idle and releases both lines at once, well inside the abort limit
			state_nxt = DS_IDLE; // see (R5) see (R9)
			sda_oe_nxt = 1'b0;
			scl_oe_nxt = 1'b0;
		end else if (start_ev) begin
			// Only the host's START opens a transaction
			state_nxt = DS_ADDR; // see (R4) see (R11)
			bit_nxt = 4'h0;
			sda_oe_nxt = 1'b0;
			scl_oe_nxt = 1'b0;
		end else if (stop_ev) begin
			if (state_r inside {DS_WR, DS_WACK, DS_SKIP} && !rnw_r && nbytes_r != 3'h0) begin
				busy_nxt = 32'(WRITE_CYC); // see (R14)
				commit_nxt = 1'b1;
			end
			nbytes_nxt = 3'h0;
			state_nxt = DS_IDLE;
			sda_oe_nxt = 1'b0;
			scl_oe_nxt = 1'b0;
		end else begin
			unique case (state_r)
				DS_IDLE, DS_SKIP: begin
					sda_oe_nxt = 1'b0;
					scl_oe_nxt = 1'b0;
				end
				DS_ADDR: begin
					if (rise) begin
						bit_nxt = bit_r + 4'h1;
					end else if (fall && bit_r == 4'h8) begin
						// Busy with a write cycle: stay silent until done
						if (hit && busy_r == 32'h0) begin
							half_nxt = (addr == OMS_RX_ADDR);
							rnw_nxt = (byte_s[0] == OMS_RD_BIT);
							nbytes_nxt = 3'h0;
							sda_oe_nxt = 1'b1;
							state_nxt = DS_AACK;
						end else begin
							state_nxt = DS_SKIP; // see (R15) see (R14)
						end
					end
				end
				DS_AACK: begin
					if (fall) begin
						sda_oe_nxt = 1'b0;
						bit_nxt = 4'h0;
						if (rnw_r) begin
							scl_oe_nxt = 1'b1;
							rd_req_nxt = 1'b1;
							cnt_nxt = 32'h0;
							state_nxt = DS_FETCH;
						end else begin
							state_nxt = DS_WR;
						end
					end
				end
				DS_WR: begin
					if (rise) begin
						bit_nxt = bit_r + 4'h1;
					end else if (fall && bit_r == 4'h8) begin
						if (nbytes_r < OMS_MAX_WR) begin
							wr_valid_nxt = 1'b1;
							wr_index_nxt = nbytes_r[1:0];
							wr_data_nxt = byte_s;
							nbytes_nxt = nbytes_r + 3'h1;
							sda_oe_nxt = 1'b1;
							state_nxt = DS_WACK;
						end else begin
							// A fifth byte is refused and not stored
							state_nxt = DS_SKIP; // see (R13)
						end
					end
				end
				DS_WACK: begin
					if (fall) begin
						sda_oe_nxt = 1'b0;
						bit_nxt = 4'h0;
						state_nxt = DS_WR;
					end
				end
				DS_FETCH: begin
					// Clock held low until data arrives or the stretch limit
					cnt_nxt = cnt_r + 32'h1;
					if (rd_valid_in || cnt_r == 32'(STRETCH_CYC - 1)) begin // see (R12)
						sh_nxt = rd_valid_in ? rd_data_in : OMS_IDLE_BYTE;
						sda_oe_nxt = rd_valid_in ? ~rd_data_in[7] : 1'b0;
						scl_oe_nxt = 1'b0;
						nbytes_nxt = nbytes_r + 3'h1;
						bit_nxt = 4'h0;
						state_nxt = DS_RD;
					end
				end
				DS_RD: begin
					if (rise) begin
						bit_nxt = bit_r + 4'h1;
					end else if (fall) begin
						if (bit_r == 4'h8) begin
							sda_oe_nxt = 1'b0;
							state_nxt = DS_RACK;
						end else begin
							sh_nxt = {sh_r[6:0], 1'b1};
							sda_oe_nxt = ~sh_r[6];
						end
					end
				end
				DS_RACK: begin
					if (rise) begin
						mack_nxt = ~sda_s;
					end else if (fall) begin
						bit_nxt = 4'h0;
						if (mack_r) begin
							scl_oe_nxt = 1'b1;
							rd_req_nxt = 1'b1;
							cnt_nxt = 32'h0;
							state_nxt = DS_FETCH;
						end else begin
							state_nxt = DS_SKIP;
						end
					end
				end
				default: begin
					state_nxt = DS_IDLE;
					sda_oe_nxt = 1'b0;
					scl_oe_nxt = 1'b0;
				end
			endcase
		end
	end

	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			state_r <= DS_IDLE;
			bit_r <= 4'h0;
			nbytes_r <= 3'h0;
			sh_r <= 8'h0;
			half_r <= 1'b0;
			rnw_r <= 1'b0;
			mack_r <= 1'b0;
			sda_oe_r <= 1'b0;
			scl_oe_r <= 1'b0;
			cnt_r <= 32'h0;
			busy_r <= 32'h0;
			wr_valid_r <= 1'b0;
			wr_index_r <= 2'h0;
			wr_data_r <= 8'h0;
			commit_r <= 1'b0;
			rd_req_r <= 1'b0;
		end else begin
			state_r <= state_nxt;
			bit_r <= bit_nxt;
			nbytes_r <= nbytes_nxt;
			sh_r <= sh_nxt;
			half_r <= half_nxt;
			rnw_r <= rnw_nxt;
			mack_r <= mack_nxt;
			sda_oe_r <= sda_oe_nxt;
			scl_oe_r <= scl_oe_nxt;
			cnt_r <= cnt_nxt;
			busy_r <= busy_nxt;
			wr_valid_r <= wr_valid_nxt;
			wr_index_r <= wr_index_nxt;
			wr_data_r <= wr_data_nxt;
			commit_r <= commit_nxt;
			rd_req_r <= rd_req_nxt;
		end
	end

	assign link.dev_scl_o = 1'b0;
	assign link.dev_sda_o = 1'b0;
	assign link.dev_scl_oe = scl_oe_r;
	assign link.dev_sda_oe = sda_oe_r;
	assign wr_valid_out = wr_valid_r;
	assign wr_half_out = half_r;
	assign wr_index_out = wr_index_r;
	assign wr_data_out = wr_data_r;
	assign wr_commit_out = commit_r;
	assign rd_req_out = rd_req_r;
	assign rd_half_out = half_r;
	assign rd_index_out = 2'(nbytes_r);
	assign busy_out = (busy_r != 32'h0);
endmodule // oms_dev_end

// >>> rtl/oms_host_end.sv
// Host end: two-wire bus master with module select sequencing
`timescale 1ns/100ps
module oms_host_end #(
	parameter int SETUP_CYC = oms_pkg::OMS_SEL_SETUP_CYC
) (
	input wire logic clk_in,
	input wire logic arst_n_in,
	oms_link_if.host link,
	input wire logic cmd_valid_in,
	output logic cmd_ready_out,
	input wire logic cmd_read_in,
	input wire logic cmd_half_in,
	input wire logic [2:0] cmd_len_in,
	input wire logic [31:0] cmd_wdata_in,
	output logic done_out,
	output logic nack_out,
	output logic [31:0] rdata_out
);
	import oms_pkg::*;

	typedef enum logic [2:0] {
		HS_IDLE = 3'h0,
		HS_SETUP = 3'h1,
		HS_START = 3'h3,
		HS_BIT = 3'h2,
		HS_STOP = 3'h6,
		HS_HOLD = 3'h7
	} oms_hstate_type;

	logic [1:0] s1_r;
	logic [1:0] s2_r;
	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			s1_r <= 2'h3;
			s2_r <= 2'h3;
		end else begin
			s1_r <= {link.sda, link.scl};
			s2_r <= s1_r;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	oms_hstate_type state_r, state_nxt;
	logic [31:0] cnt_r, cnt_nxt;
	logic [1:0] ph_r, ph_nxt;
	logic [3:0] bit_r, bit_nxt;
	logic [2:0] idx_r, idx_nxt;
	logic [2:0] len_r, len_nxt;
	logic [7:0] tx_r, tx_nxt;
	logic [7:0] rx_r, rx_nxt;
	logic [31:0] wdata_r, wdata_nxt;
	logic [31:0] rdata_r, rdata_nxt;
	logic read_r, read_nxt;
	logic nack_r, nack_nxt;
	logic done_r, done_nxt;
	logic sel_n_r, sel_n_nxt;
	logic scl_oe_r, scl_oe_nxt;
	logic sda_oe_r, sda_oe_nxt;
	logic tick;
	logic step;
	logic sending;
	logic [1:0] k;

	assign tick = (cnt_r == 32'(OMS_QTR_CYC - 1));
	// A slave holding the clock low stalls the high phase
	assign step = tick && !(ph_r == 2'h2 && !s2_r[0]);
	assign sending = (idx_r == 3'h0) || !read_r;
	assign k = 2'(idx_r - 3'h1);

	always_comb begin
		state_nxt = state_r;
		cnt_nxt = cnt_r;
		ph_nxt = ph_r;
		bit_nxt = bit_r;
		idx_nxt = idx_r;
		len_nxt = len_r;
		tx_nxt = tx_r;
		rx_nxt = rx_r;
		wdata_nxt = wdata_r;
		rdata_nxt = rdata_r;
		read_nxt = read_r;
		nack_nxt = nack_r;
		done_nxt = 1'b0;
		sel_n_nxt = sel_n_r;
		scl_oe_nxt = scl_oe_r;
		sda_oe_nxt = sda_oe_r;
		if (state_r inside {HS_START, HS_BIT, HS_STOP}) begin
			// A stretched clock restarts the high quarter so the high time stays full
			cnt_nxt = (tick || (ph_r == 2'h2 && !s2_r[0])) ? 32'h0 : cnt_r + 32'h1; // see (R6)
		end
		unique case (state_r)
			HS_IDLE: begin
				if (cmd_valid_in) begin
					read_nxt = cmd_read_in;
					len_nxt = (cmd_len_in == 3'h0) ? 3'h1 :
						(cmd_len_in > OMS_MAX_WR) ? OMS_MAX_WR : cmd_len_in; // see (R13)
					tx_nxt = {cmd_half_in ? OMS_RX_ADDR : OMS_TX_ADDR, cmd_read_in};
					wdata_nxt = cmd_wdata_in;
					rdata_nxt = 32'h0;
					nack_nxt = 1'b0;
					sel_n_nxt = 1'b0; // see (R3)
					cnt_nxt = 32'h0;
					state_nxt = HS_SETUP;
				end
			end
			HS_SETUP: begin
				cnt_nxt = cnt_r + 32'h1;
				if (cnt_r == 32'(SETUP_CYC - 1)) begin // see (R7)
					cnt_nxt = 32'h0;
					ph_nxt = 2'h0;
					state_nxt = HS_START;
				end
			end
			HS_START: begin
				if (step) begin
					ph_nxt = ph_r + 2'h1;
					if (ph_r == 2'h2) begin
						sda_oe_nxt = 1'b1;
					end
					if (ph_r == 2'h3) begin
						scl_oe_nxt = 1'b1;
						bit_nxt = 4'h0;
						idx_nxt = 3'h0;
						state_nxt = HS_BIT;
					end
				end
			end
			HS_BIT: begin
				if (step) begin
					ph_nxt = ph_r + 2'h1;
					unique case (ph_r)
						2'h0: begin
							if (bit_r == 4'h8) begin
								sda_oe_nxt = sending ? 1'b0 : (idx_r < len_r);
							end else begin
								sda_oe_nxt = sending ? ~tx_r[7] : 1'b0;
							end
						end
						2'h1: scl_oe_nxt = 1'b0;
						2'h2: begin
							if (bit_r == 4'h8) begin
								nack_nxt = nack_r | (sending & s2_r[1]);
							end else begin
								rx_nxt = {rx_r[6:0], s2_r[1]};
							end
						end
						2'h3: begin
							scl_oe_nxt = 1'b1;
							bit_nxt = bit_r + 4'h1;
							tx_nxt = {tx_r[6:0], 1'b1};
							if (bit_r == 4'h7 && !sending) begin
								rdata_nxt[{k, 3'h0} +: 8] = rx_r;
							end
							if (bit_r == 4'h8) begin
								bit_nxt = 4'h0;
								if (nack_r || idx_r == len_r) begin
									state_nxt = HS_STOP;
								end else begin
									idx_nxt = idx_r + 3'h1;
									tx_nxt = wdata_r[7:0];
									wdata_nxt = {8'h0, wdata_r[31:8]};
								end
							end
						end
					endcase
				end
			end
			HS_STOP: begin
				if (step) begin
					ph_nxt = ph_r + 2'h1;
					unique case (ph_r)
						2'h0: sda_oe_nxt = 1'b1;
						2'h1: scl_oe_nxt = 1'b0;
						2'h2: sda_oe_nxt = 1'b0;
						2'h3: begin
							cnt_nxt = 32'h0;
							state_nxt = HS_HOLD;
						end
					endcase
				end
			end
			HS_HOLD: begin
				// Select stays low after STOP so the module never sees a cut sequence
				cnt_nxt = cnt_r + 32'h1;
				if (cnt_r == 32'(OMS_SEL_HOLD_CYC - 1)) begin // see (R8) see (R10)
					sel_n_nxt = 1'b1;
					done_nxt = 1'b1;
					state_nxt = HS_IDLE;
				end
			end
			default: begin
				sel_n_nxt = 1'b1;
				scl_oe_nxt = 1'b0;
				sda_oe_nxt = 1'b0;
				state_nxt = HS_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			state_r <= HS_IDLE;
			cnt_r <= 32'h0;
			ph_r <= 2'h0;
			bit_r <= 4'h0;
			idx_r <= 3'h0;
			len_r <= 3'h1;
			tx_r <= 8'h0;
			rx_r <= 8'h0;
			wdata_r <= 32'h0;
			rdata_r <= 32'h0;
			read_r <= 1'b0;
			nack_r <= 1'b0;
			done_r <= 1'b0;
			sel_n_r <= 1'b1;
			scl_oe_r <= 1'b0;
			sda_oe_r <= 1'b0;
		end else begin
			state_r <= state_nxt;
			cnt_r <= cnt_nxt;
			ph_r <= ph_nxt;
			bit_r <= bit_nxt;
			idx_r <= idx_nxt;
			len_r <= len_nxt;
			tx_r <= tx_nxt;
			rx_r <= rx_nxt;
			wdata_r <= wdata_nxt;
			rdata_r <= rdata_nxt;
			read_r <= read_nxt;
			nack_r <= nack_nxt;
			done_r <= done_nxt;
			sel_n_r <= sel_n_nxt;
			scl_oe_r <= scl_oe_nxt;
			sda_oe_r <= sda_oe_nxt;
		end
	end

	assign link.host_scl_o = 1'b0;
	assign link.host_sda_o = 1'b0;
	assign link.host_scl_oe = scl_oe_r;
	assign link.host_sda_oe = sda_oe_r;
	assign link.module_select_n = sel_n_r;
	assign cmd_ready_out = (state_r == HS_IDLE);
	assign done_out = done_r;
	assign nack_out = nack_r;
	assign rdata_out = rdata_r;
endmodule // oms_host_end

// >>> test/oms_link_properties.sv
// Checker for the host-to-module two-wire link with module select
`timescale 1ns/100ps
module oms_link_properties #(
	parameter int SETUP_CYC = 50,
	parameter int STRETCH_CYC = 20
) (
	input wire logic clk_in,
	input wire logic arst_n_in,
	input wire logic dev_scl_oe,
	input wire logic dev_sda_oe,
	input wire logic module_select_n,
	input wire logic scl,
	input wire logic sda
);
	localparam int HOLD_CYC = 1000;
	logic scl_r, sda_r, frame_r;
	logic [31:0] sel_low_r, stop_age_r, rise_age_r, stretch_r;
	logic start_w, stop_w;
	assign start_w = scl & scl_r & sda_r & ~sda;
	assign stop_w = scl & scl_r & ~sda_r & sda;
	////////////////////////////////////////////////////////////////////////////////
	// Ages start large so the first frame after reset is not flagged
	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			scl_r <= 1'b1;
			sda_r <= 1'b1;
			frame_r <= 1'b0;
			sel_low_r <= 32'h0;
			stop_age_r <= 32'h00ff_ffff;
			rise_age_r <= 32'h00ff_ffff;
			stretch_r <= 32'h0;
		end else begin
			scl_r <= scl;
			sda_r <= sda;
			frame_r <= start_w | (frame_r & ~stop_w);
			sel_low_r <= module_select_n ? 32'h0 : sel_low_r + 32'h1;
			stop_age_r <= stop_w ? 32'h0 : stop_age_r + 32'h1;
			rise_age_r <= (scl & ~scl_r) ? 32'h0 : rise_age_r + 32'h1;
			stretch_r <= dev_scl_oe ? stretch_r + 32'h1 : 32'h0;
		end
	end
	////////////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!arst_n_in);
	property p_start_setup;
		start_w |-> sel_low_r >= SETUP_CYC - 1;
	endproperty
	a_start_setup: assert property (p_start_setup) else $error("select set-up short");
	property p_frame_select;
		frame_r |-> !module_select_n;
	endproperty
	a_frame_select: assert property (p_frame_select) else $error("select high in frame");
	property p_select_hold;
		$changed(module_select_n) |-> stop_age_r >= HOLD_CYC - 2;
	endproperty
	a_select_hold: assert property (p_select_hold) else $error("select hold short");
	property p_scl_rate;
		$rose(scl) |-> rise_age_r >= 249;
	endproperty
	a_scl_rate: assert property (p_scl_rate) else $error("link clock too fast");
	property p_stretch;
		dev_scl_oe |-> stretch_r <= STRETCH_CYC + 8;
	endproperty
	a_stretch: assert property (p_stretch) else $error("clock stretch too long");
	property p_desel_release;
		$rose(module_select_n) |-> ##3 (!dev_scl_oe && !dev_sda_oe);
	endproperty
	a_desel_release: assert property (p_desel_release) else $error("lines held");
	property p_desel_quiet;
		module_select_n [*4] |-> (!dev_scl_oe && !dev_sda_oe);
	endproperty
	a_desel_quiet: assert property (p_desel_quiet) else $error("deselected end drives");
	property p_dev_sda_low;
		$changed(dev_sda_oe) |-> !scl;
	endproperty
	a_dev_sda_low: assert property (p_dev_sda_low) else $error("data moved, clock high");
	property p_dev_scl_extend;
		$rose(dev_scl_oe) |-> !$past(scl);
	endproperty
	a_dev_scl_extend: assert property (p_dev_scl_extend) else $error("clock pulled");
endmodule // oms_link_properties

// >>> test/optical_module_mgmt_select_i2c_test.sv
// Bench joining host end and module end, plus a hand-driven second link
`timescale 1ns/100ps
module optical_module_mgmt_select_i2c_test;
	localparam int SETUP = 50;
	localparam int STRETCH = 20;
	localparam int WRCYC = 4000;
	localparam int HOLD = 1000;
	localparam int QTR = 63;
	logic clk_in, arst_n_in, cmd_valid, cmd_ready, cmd_read, cmd_half, done, nack;
	logic wr_valid, wr_half, wr_commit, rd_req, rd_half, rd_valid, busy, resp_on;
	logic [2:0] cmd_len;
	logic [31:0] cmd_wdata, rdata;
	logic [1:0] wr_index, rd_index;
	logic [7:0] wr_data, rd_data;
	logic [10:0] wr_q[$];
	int n_errors, cmp_count, commits;
	oms_link_if lk();
	oms_link_if lk_2();
	oms_host_end #(.SETUP_CYC(SETUP)) i_oms_host_end (.clk_in(clk_in), .arst_n_in(arst_n_in),
		.link(lk), .cmd_valid_in(cmd_valid), .cmd_ready_out(cmd_ready), .cmd_read_in(cmd_read),
		.cmd_half_in(cmd_half), .cmd_len_in(cmd_len), .cmd_wdata_in(cmd_wdata),
		.done_out(done), .nack_out(nack), .rdata_out(rdata));
	oms_dev_end #(.STRETCH_CYC(STRETCH), .WRITE_CYC(WRCYC)) i_oms_dev_end (.clk_in(clk_in),
		.arst_n_in(arst_n_in), .link(lk), .wr_valid_out(wr_valid), .wr_half_out(wr_half),
		.wr_index_out(wr_index), .wr_data_out(wr_data), .wr_commit_out(wr_commit),
		.rd_req_out(rd_req), .rd_half_out(rd_half), .rd_index_out(rd_index),
		.rd_data_in(rd_data), .rd_valid_in(rd_valid), .busy_out(busy));
	// Second end faces the bench, which breaks the select rules on purpose
	oms_dev_end #(.STRETCH_CYC(STRETCH), .WRITE_CYC(WRCYC)) i_oms_dev_end_2 (.clk_in(clk_in),
		.arst_n_in(arst_n_in), .link(lk_2), .wr_valid_out(), .wr_half_out(), .wr_index_out(),
		.wr_data_out(), .wr_commit_out(), .rd_req_out(), .rd_half_out(), .rd_index_out(),
		.rd_data_in(8'h00), .rd_valid_in(1'b0), .busy_out());
	oms_link_properties #(.SETUP_CYC(SETUP), .STRETCH_CYC(STRETCH)) i_oms_link_properties (
		.clk_in(clk_in), .arst_n_in(arst_n_in), .dev_scl_oe(lk.dev_scl_oe),
		.dev_sda_oe(lk.dev_sda_oe), .module_select_n(lk.module_select_n), .scl(lk.scl),
		.sda(lk.sda));
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		clk_in = 1'b0;
		forever #5 clk_in = ~clk_in;
	end
	always @(posedge clk_in) begin
		if (wr_valid === 1'b1) wr_q.push_back({wr_half, wr_index, wr_data});
		if (wr_commit === 1'b1) commits++;
	end
	// Answer a fetch one cycle late with a byte that encodes half and index
	always @(negedge clk_in) begin
		rd_valid <= 1'b0;
		if (rd_req === 1'b1 && resp_on) begin
			rd_valid <= 1'b1;
			rd_data <= {5'h06, rd_half, rd_index};
		end
	end
	////////////////////////////////////////////////////////////////////////////////
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			n_errors++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic report_and_stop;
		if (n_errors == 0 && cmp_count > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	task automatic run_cmd(input logic rd, half, input logic [2:0] len, input logic [31:0] wd);
		int i;
		@(negedge clk_in);
		check({31'h0, cmd_ready}, 32'h1);
		cmd_valid = 1'b1;
		cmd_read = rd;
		cmd_half = half;
		cmd_len = len;
		cmd_wdata = wd;
		@(negedge clk_in);
		cmd_valid = 1'b0;
		for (i = 0; i < 20000 && done !== 1'b1; i++) @(negedge clk_in);
		check({31'h0, done}, 32'h1);
	endtask
	task automatic t_write4;
		int i;
		wr_q.delete();
		commits = 0;
		run_cmd(1'b0, 1'b0, 3'h7, 32'h44332211);
		check({31'h0, nack}, 32'h0);
		check(wr_q.size(), 4);
		for (i = 0; i < 4 && i < wr_q.size(); i++)
			check({21'h0, wr_q[i]}, {21'h0, 1'b0, 2'(i), 8'h11 * 8'(i + 1)});
		check(commits, 1);
		check({31'h0, busy}, 32'h1);
	endtask
	task automatic t_busy;
		run_cmd(1'b0, 1'b0, 3'h1, 32'h77);
		check({31'h0, nack}, 32'h1);
		check(wr_q.size(), 4);
		check({31'h0, busy}, 32'h0);
	endtask
	task automatic t_write_rx;
		int i;
		wr_q.delete();
		run_cmd(1'b0, 1'b1, 3'h0, 32'h5a);
		check({31'h0, nack}, 32'h0);
		check(wr_q.size(), 1);
		if (wr_q.size() > 0) check({21'h0, wr_q[0]}, 32'h45a);
		for (i = 0; i < 5000 && busy !== 1'b0; i++) @(negedge clk_in);
		check({31'h0, busy}, 32'h0);
	endtask
	task automatic t_reads;
		resp_on = 1'b1;
		run_cmd(1'b1, 1'b1, 3'h2, 32'h0);
		check({31'h0, nack}, 32'h0);
		check(rdata, 32'h0000_3534);
		resp_on = 1'b0;
		// Silent user: the stretch must give up and send all ones
		run_cmd(1'b1, 1'b0, 3'h1, 32'h0);
		check(rdata, 32'h0000_00ff);
	endtask
	////////////////////////////////////////////////////////////////////////////////
	task automatic bb_q;
		repeat (QTR) @(negedge clk_in);
	endtask
	task automatic bb_bit(input logic b, output logic got);
		lk_2.host_sda_oe = ~b;
		bb_q();
		lk_2.host_scl_oe = 1'b0;
		bb_q();
		got = lk_2.sda;
		bb_q();
		lk_2.host_scl_oe = 1'b1;
		bb_q();
	endtask
	task automatic bb_head(input logic sel_n, input logic [7:0] a);
		logic g;
		int i;
		repeat (HOLD) @(negedge clk_in);
		lk_2.module_select_n = sel_n;
		repeat (SETUP) @(negedge clk_in);
		lk_2.host_sda_oe = 1'b1;
		bb_q();
		lk_2.host_scl_oe = 1'b1;
		bb_q();
		for (i = 7; i >= 0; i--) bb_bit(a[i], g);
	endtask
	task automatic bb_frame(input logic sel_n, input logic [7:0] a, input logic ack);
		logic g;
		bb_head(sel_n, a);
		bb_bit(1'b1, g);
		check({31'h0, ~g}, {31'h0, ack});
		lk_2.host_sda_oe = 1'b1;
		bb_q();
		lk_2.host_scl_oe = 1'b0;
		bb_q();
		lk_2.host_sda_oe = 1'b0;
		bb_q();
	endtask
	task automatic t_abort;
		bb_head(1'b0, 8'ha0);
		lk_2.host_sda_oe = 1'b0;
		bb_q();
		check({31'h0, lk_2.dev_sda_oe}, 32'h1);
		lk_2.module_select_n = 1'b1;
		repeat (5) @(negedge clk_in);
		check({30'h0, lk_2.dev_scl_oe, lk_2.dev_sda_oe}, 32'h0);
		lk_2.host_scl_oe = 1'b0;
		bb_q();
	endtask
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		#950000;
		n_errors++;
		report_and_stop();
	end
	initial begin
		{n_errors, cmp_count, commits} = '0;
		{cmd_valid, cmd_read, cmd_half, cmd_len, cmd_wdata, rd_data, rd_valid, resp_on} = '0;
		{lk_2.host_scl_o, lk_2.host_sda_o, lk_2.host_scl_oe, lk_2.host_sda_oe} = 4'h0;
		lk_2.module_select_n = 1'b1;
		arst_n_in = 1'b0;
		repeat (12) @(negedge clk_in);
		arst_n_in = 1'b1;
		repeat (2) @(negedge clk_in);
		t_write4();
		t_busy();
		t_write_rx();
		t_reads();
		bb_frame(1'b1, 8'ha0, 1'b0);
		bb_frame(1'b0, 8'ha4, 1'b0);
		bb_frame(1'b0, 8'ha8, 1'b1);
		t_abort();
		bb_frame(1'b0, 8'ha0, 1'b1);
		report_and_stop();
	end
endmodule // optical_module_mgmt_select_i2c_test
